// ===== logic/ppr_port_top.sv
// Port 2/3 pin logic with reset-pin sharing, external interrupts and AHB-Lite registers.
// Assumes pins synchronous to hclk; board resolves pin level from out/oe and pulls.
`timescale 1ns/1ps
`include "ppr_params.svh"
module ppr_port_top #(
  parameter int READ_CYC = `PPR_CFG_READ_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Port 2 pins
  input  wire logic [7:0]  port2_in,
  output logic [7:0]       port2_out,
  output logic [7:0]       port2_oe,
  // Port 3 pins
  input  wire logic [7:0]  port3_in,
  output logic [7:0]       port3_out,
  output logic [7:0]       port3_oe,
  // Reset-time pull controls
  output logic             pulldown_port2_bit2,
  output logic             pulldown_port2_bit3,
  output logic             pullup_port3_bit4,
  // Configuration and core reset
  input  wire logic [7:0]  cfg_byte,
  output logic             core_reset_n,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------
  // Read-modify-write of one port bit
  // ----------------------------------------
  // Input pins read back pin level, so their latches take it.
  function automatic logic [7:0] ppr_rmw(input logic [7:0] mode,
                                         input logic [7:0] latch,
                                         input logic [7:0] pins,
                                         input logic [2:0] idx,
                                         input logic       val);
    logic [7:0] rd;
    rd      = (mode & pins) | (~mode & latch);
    rd[idx] = val;
    return rd;
  endfunction

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  logic       core_run;
  logic       reset_role;
  logic [7:0] cfg_held;

  ppr_reset_seq #(
    .READ_CYC   (READ_CYC)
  ) u_seq (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .shared_pin (port3_in[4]),
    .cfg_byte   (cfg_byte),
    .core_run   (core_run),
    .reset_role (reset_role),
    .cfg_held   (cfg_held)
  );

  assign core_reset_n        = core_run;
  assign pulldown_port2_bit2 = !core_run;
  assign pulldown_port2_bit3 = !core_run;
  assign pullup_port3_bit4   = !core_run;

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  logic       wr_pend;
  logic       rd_first;
  logic [7:0] dph_addr;

  wire addr_valid = hsel & hready & htrans[1] & (hsize == 3'b010);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      rd_first <= 1'b0;
      dph_addr <= 8'h00;
    end else begin
      wr_pend  <= addr_valid & hwrite;
      rd_first <= addr_valid & ~hwrite;
      if (addr_valid) begin
        dph_addr <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state so that a just-written value is seen
  assign hreadyout = ~rd_first;
  assign hresp     = 1'b0;

  wire wr_p2l  = wr_pend & (dph_addr == `PPR_OFF_P2_LATCH);
  wire wr_p2m  = wr_pend & (dph_addr == `PPR_OFF_P2_MODE);
  wire wr_p3l  = wr_pend & (dph_addr == `PPR_OFF_P3_LATCH);
  wire wr_p3m  = wr_pend & (dph_addr == `PPR_OFF_P3_MODE);
  wire wr_bop  = wr_pend & (dph_addr == `PPR_OFF_BIT_OP);
  wire wr_ist  = wr_pend & (dph_addr == `PPR_OFF_INT_STAT);
  wire wr_imk  = wr_pend & (dph_addr == `PPR_OFF_INT_MASK);

  wire [2:0] bop_idx = hwdata[`PPR_BITOP_IDX_LSB +: 3];
  wire       bop_val = hwdata[`PPR_BITOP_VAL];
  wire       bitop_p2 = wr_bop & ~hwdata[`PPR_BITOP_PORT];
  wire       bitop_p3 = wr_bop &  hwdata[`PPR_BITOP_PORT];

  // ----------------------------------------
  // Port latches and modes
  // ----------------------------------------
  logic [7:0] p2_latch;
  logic [7:0] p2_mode;
  logic [7:0] p3_latch;
  logic [7:0] p3_mode;

  wire [7:0] rmw_p2 = ppr_rmw(p2_mode, p2_latch, port2_in, bop_idx, bop_val);
  wire [7:0] rmw_p3 = ppr_rmw(p3_mode, p3_latch, port3_in, bop_idx, bop_val);

  wire [7:0] next_p2_latch = bitop_p2 ? rmw_p2 :
                             wr_p2l   ? hwdata[7:0] : p2_latch;
  wire [7:0] next_p3_latch = bitop_p3 ? rmw_p3 :
                             wr_p3l   ? hwdata[7:0] : p3_latch;
  wire [7:0] next_p2_mode  = wr_p2m ? hwdata[7:0] : p2_mode;
  wire [7:0] next_p3_mode  = wr_p3m ? hwdata[7:0] : p3_mode;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p2_latch <= `PPR_RST_LATCH;
      p3_latch <= `PPR_RST_LATCH;
      p2_mode  <= `PPR_RST_MODE;
      p3_mode  <= `PPR_RST_MODE;
    end else if (!core_run) begin
      p2_latch <= `PPR_RST_LATCH;
      p3_latch <= `PPR_RST_LATCH;
      p2_mode  <= `PPR_RST_MODE;
      p3_mode  <= `PPR_RST_MODE;
    end else begin
      p2_latch <= next_p2_latch;
      p3_latch <= next_p3_latch;
      p2_mode  <= next_p2_mode;
      p3_mode  <= next_p3_mode;
    end
  end

  // Port 3 bit 4 is input only; drivers stay off during reset
  assign port2_out = p2_latch;
  assign port3_out = p3_latch;
  assign port2_oe  = ~p2_mode & {8{core_run}};
  assign port3_oe  = ~p3_mode & {8{core_run}} & 8'hef;

  // ----------------------------------------
  // External interrupts on two pins
  // ----------------------------------------
  logic [1:0] int_stat;
  logic [1:0] int_mask;
  logic [1:0] prev_lvl;

  // Seen level is the driven level in output mode
  wire lvl_p2b1 = p2_mode[1] ? port2_in[1] : p2_latch[1];
  wire lvl_p3b2 = p3_mode[2] ? port3_in[2] : p3_latch[2];
  wire [1:0] cur_lvl = {lvl_p3b2, lvl_p2b1};
  wire [1:0] evt     = (cur_lvl ^ prev_lvl) & {2{core_run}};
  wire [1:0] w1c     = wr_ist ? hwdata[1:0] : 2'h0;

  // Set wins over a clear in the same cycle
  wire [1:0] next_int_stat = (int_stat & ~w1c) | evt;
  wire [1:0] next_int_mask = wr_imk ? hwdata[1:0] : int_mask;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat <= 2'h0;
      int_mask <= `PPR_RST_MASK;
      prev_lvl <= 2'h0;
    end else if (!core_run) begin
      int_stat <= 2'h0;
      int_mask <= `PPR_RST_MASK;
      prev_lvl <= cur_lvl;
    end else begin
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      prev_lvl <= cur_lvl;
    end
  end

  // Mask bit high suppresses the request
  assign irq = |(int_stat & ~int_mask);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    case (dph_addr)
      `PPR_OFF_P2_LATCH:  rd_mux = {24'h000000, p2_latch};
      `PPR_OFF_P2_MODE:   rd_mux = {24'h000000, p2_mode};
      `PPR_OFF_P3_LATCH:  rd_mux = {24'h000000, p3_latch};
      `PPR_OFF_P3_MODE:   rd_mux = {24'h000000, p3_mode};
      `PPR_OFF_PIN_LEVEL: rd_mux = {16'h0000, port3_in, port2_in};
      `PPR_OFF_INT_STAT:  rd_mux = {30'h00000000, int_stat};
      `PPR_OFF_INT_MASK:  rd_mux = {30'h00000000, int_mask};
      `PPR_OFF_CFG_STAT:  rd_mux = {23'h000000, reset_role, cfg_held};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_first) begin
      hrdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire [7:0] bop_mask = 8'h01 << bop_idx;
  wire [7:0] p2_other = p2_mode & ~bop_mask;
  wire [7:0] p3_other = p3_mode & ~bop_mask;
  wire [7:0] p2_keep  = ~p2_mode & ~bop_mask;
  wire [7:0] p3_keep  = ~p3_mode & ~bop_mask;

  pull_down_reset_a: assert property (
    !core_run |-> (pulldown_port2_bit2 && pulldown_port2_bit3))
    else $error("Pull-downs not active in reset");

  pull_up_reset_a: assert property (
    pullup_port3_bit4 == !core_run)
    else $error("Pull-up does not follow core reset");

  oe_reset_off_a: assert property (
    !core_run |-> ((port2_oe == 8'h00) && (port3_oe == 8'h00)))
    else $error("Pin driven while core in reset");

  reset_mode_in_a: assert property (
    !core_run |=> ((p2_mode == `PPR_RST_MODE) && (p3_mode == `PPR_RST_MODE)))
    else $error("Port mode not input during reset");

  shared_no_drive_a: assert property (
    !port3_oe[4])
    else $error("Shared reset pin driven");

  input_role_hold_a: assert property (
    (core_run && !reset_role) |=> core_run)
    else $error("Input-role pin caused reset");

  role_stable_a: assert property (
    (core_run && $past(core_run)) |-> $stable(reset_role))
    else $error("Pin role changed while running");

  cfg_latch_a: assert property (
    $rose(core_run) |-> (cfg_held == $past(cfg_byte)))
    else $error("Configuration byte not latched at release");

  low_pin_hold_a: assert property (
    (!core_run && !port3_in[4]) |=> !core_run [*2])
    else $error("Reset released with shared pin low");

  run_needs_pin_a: assert property (
    $rose(core_run) |-> $past(port3_in[4]))
    else $error("Release without shared pin high");

  out_change_flag_a: assert property (
    (core_run && !p2_mode[1] && (lvl_p2b1 != prev_lvl[0])) |=> int_stat[0])
    else $error("Output change did not set flag");

  out_change_p3_a: assert property (
    (core_run && !p3_mode[2] && (lvl_p3b2 != prev_lvl[1])) |=> int_stat[1])
    else $error("Port 3 output change did not set flag");

  flag_sticky_a: assert property (
    (core_run && int_stat[0] && !(wr_ist && hwdata[0])) |=> int_stat[0])
    else $error("Interrupt flag lost without clear");

  set_wins_a: assert property (
    (evt[0] && wr_ist && hwdata[0]) |=> int_stat[0])
    else $error("Clear won over a same-cycle event");

  no_event_reset_a: assert property (
    !core_run |=> (int_stat == 2'h0))
    else $error("Interrupt flag set during core reset");

  mask_suppress_a: assert property (
    (int_mask == 2'h3) |-> !irq)
    else $error("Masked flag raised the interrupt");

  bitop_rmw_a: assert property (
    (bitop_p2 && core_run) |=>
      ((p2_latch[$past(bop_idx)] == $past(bop_val)) &&
       ((p2_latch & $past(p2_keep)) == ($past(p2_latch) & $past(p2_keep)))))
    else $error("Bit operation did not rewrite all latches");

  bitop_rmw_p3_a: assert property (
    (bitop_p3 && core_run) |=>
      ((p3_latch[$past(bop_idx)] == $past(bop_val)) &&
       ((p3_latch & $past(p3_keep)) == ($past(p3_latch) & $past(p3_keep)))))
    else $error("Port 3 bit operation did not rewrite all latches");

  input_latch_take_a: assert property (
    (bitop_p2 && core_run) |=>
      ((p2_latch & $past(p2_other)) == ($past(port2_in) & $past(p2_other))))
    else $error("Input-mode latch not loaded from pin");

  input_latch_p3_a: assert property (
    (bitop_p3 && core_run) |=>
      ((p3_latch & $past(p3_other)) == ($past(port3_in) & $past(p3_other))))
    else $error("Port 3 input-mode latch not loaded from pin");

  read_wait_a: assert property (
    (addr_valid && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state wrong");

  write_zero_wait_a: assert property (
    (addr_valid && hwrite) |=> hreadyout)
    else $error("Write data phase stalled");

  resp_okay_a: assert property (
    hresp == 1'b0)
    else $error("Error response driven");

  bitop_cov: cover property (bitop_p2 && core_run);
  bitop_p3_cov: cover property (bitop_p3 && core_run);
  ext_reset_cov: cover property ((core_run && reset_role) ##1 !core_run);
  input_role_cov: cover property (core_run && !reset_role && !port3_in[4]);
  irq_cov: cover property (int_stat[0] && irq);

endmodule // ppr_port_top

// ===== logic/ppr_params.svh
// Constants of the port pin and reset-pin block.
// Assumes a 50 MHz hclk and a word-wide AHB-Lite register bus.
`ifndef PPR_PARAMS_SVH
`define PPR_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PPR_OFF_P2_LATCH  8'h00
`define PPR_OFF_P2_MODE   8'h04
`define PPR_OFF_P3_LATCH  8'h08
`define PPR_OFF_P3_MODE   8'h0c
`define PPR_OFF_PIN_LEVEL 8'h10
`define PPR_OFF_BIT_OP    8'h14
`define PPR_OFF_INT_STAT  8'h18
`define PPR_OFF_INT_MASK  8'h1c
`define PPR_OFF_CFG_STAT  8'h20

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PPR_BITOP_IDX_LSB 0
`define PPR_BITOP_PORT    3
`define PPR_BITOP_VAL     8
`define PPR_CFG_ROLE_BIT  0
`define PPR_CFG_ROLE_FLD  8
`define PPR_INT_P2B1      0
`define PPR_INT_P3B2      1
`define PPR_RST_LATCH     8'h00
`define PPR_RST_MODE      8'hff
`define PPR_RST_MASK      2'h3
`define PPR_RST_CFG       8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define PPR_CLK_NS        20
`define PPR_CFG_READ_NS   200
`define PPR_CFG_READ_CYC  ((`PPR_CFG_READ_NS + `PPR_CLK_NS - 1) / `PPR_CLK_NS)

`endif

// ===== logic/ppr_pkg.sv
// Types of the port pin and reset-pin block.
// Assumes ppr_params.svh for all numeric constants.
package ppr_pkg;

  // ----------------------------------------
  // Reset sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ppr_st_read = 2'b01,
    ppr_st_run  = 2'b10
  } ppr_seq_t;

endpackage

// ===== logic/ppr_reset_seq.sv
// Reset release sequencer: reads the configuration byte, then runs.
// Assumes a synchronous shared pin level and a stable configuration byte.
`timescale 1ns/1ps
`include "ppr_params.svh"
module ppr_reset_seq #(
  parameter int READ_CYC = `PPR_CFG_READ_CYC
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Shared pin and configuration byte
  input  wire logic       shared_pin,
  input  wire logic [7:0] cfg_byte,
  // Results
  output logic            core_run,
  output logic            reset_role,
  output logic [7:0]      cfg_held
);

  ppr_pkg::ppr_seq_t state;
  logic [7:0]        cnt;

  wire read_end = (cnt == 8'(READ_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= ppr_pkg::ppr_st_read;
      cnt      <= 8'h00;
      cfg_held <= `PPR_RST_CFG;
    end else begin
      case (state)
        ppr_pkg::ppr_st_read: begin
          if (!shared_pin) begin
            cnt <= 8'h00;
          end else if (read_end) begin
            cfg_held <= cfg_byte;
            state    <= ppr_pkg::ppr_st_run;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        ppr_pkg::ppr_st_run: begin
          if (reset_role && !shared_pin) begin
            state <= ppr_pkg::ppr_st_read;
            cnt   <= 8'h00;
          end
        end
        default: begin
          state <= ppr_pkg::ppr_st_read;
          cnt   <= 8'h00;
        end
      endcase
    end
  end

  assign core_run   = (state == ppr_pkg::ppr_st_run);
  assign reset_role = cfg_held[`PPR_CFG_ROLE_BIT];

endmodule // ppr_reset_seq

// ===== tb/ppr_board_model.sv
// Board model: resolves port 2/3 pin levels from drivers, pulls and bench sources.
// Assumes the bench drives ext lines after rising edges; undriven lines toggle unless pulled.
`timescale 1ns/1ps
module ppr_board_model (
  // Clock
  input  wire logic       hclk,
  // Device drivers and pulls
  input  wire logic [7:0] port2_out,
  input  wire logic [7:0] port2_oe,
  input  wire logic [7:0] port3_out,
  input  wire logic [7:0] port3_oe,
  input  wire logic       pulldown_port2_bit2,
  input  wire logic       pulldown_port2_bit3,
  input  wire logic       pullup_port3_bit4,
  // Outside sources
  input  wire logic [7:0] ext2,
  input  wire logic [7:0] ext2_en,
  input  wire logic [7:0] ext3,
  input  wire logic [7:0] ext3_en,
  // Resolved levels
  output logic [7:0]      port2_in,
  output logic [7:0]      port3_in
);
  logic flip = 1'b0;
  always @(posedge hclk) flip <= ~flip;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port2_in[i] = port2_oe[i] ? port2_out[i] : ext2_en[i] ? ext2[i] : flip ^ i[0];
      port3_in[i] = port3_oe[i] ? port3_out[i] : ext3_en[i] ? ext3[i] : flip ^ i[0];
    end
    if (!port2_oe[2] && !ext2_en[2] && pulldown_port2_bit2) port2_in[2] = 1'b0;
    if (!port2_oe[3] && !ext2_en[3] && pulldown_port2_bit3) port2_in[3] = 1'b0;
    if (!port3_oe[4] && !ext3_en[4] && pullup_port3_bit4) port3_in[4] = 1'b1;
  end
endmodule // ppr_board_model

// ===== tb/ppr_port_top_tb_top.sv
// Testbench of the port pin block: AHB-Lite master, board model, random bit ops.
// Assumes ppr_port_top with a short configuration read count.
`timescale 1ns/1ps
`include "ppr_params.svh"
module ppr_port_top_tb_top;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        hreadyout, hresp, irq, core_reset_n, pd2, pd3, pu4;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv, lf = 32'hf57a;
  logic [7:0]  cfg_byte = 8'h00, p2i, p2o, p2e, p3i, p3o, p3e, m, lat, pins, ex;
  logic [7:0]  ext2 = 8'h00, ext2_en = 8'hf3, ext3 = 8'h10, ext3_en = 8'hef;
  int          fails = 0, check_count = 0;
  always #10 hclk = ~hclk;
  ppr_port_top #(.READ_CYC(2)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .port2_in(p2i), .port2_out(p2o), .port2_oe(p2e), .port3_in(p3i), .port3_out(p3o),
    .port3_oe(p3e), .pulldown_port2_bit2(pd2), .pulldown_port2_bit3(pd3),
    .pullup_port3_bit4(pu4), .cfg_byte(cfg_byte), .core_reset_n(core_reset_n), .irq(irq));
  ppr_board_model board (.hclk(hclk), .port2_out(p2o), .port2_oe(p2e), .port3_out(p3o),
    .port3_oe(p3e), .pulldown_port2_bit2(pd2), .pulldown_port2_bit3(pd3),
    .pullup_port3_bit4(pu4), .ext2(ext2), .ext2_en(ext2_en), .ext3(ext3),
    .ext3_en(ext3_en), .port2_in(p2i), .port3_in(p3i));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task results();
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Bus cycles start at a rising edge; they end at one, so calls run back to back
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task wait_core(input logic lvl);
    for (int k = 0; k < 40 && core_reset_n !== lvl; k++) @(posedge hclk);
    chk(32'(core_reset_n), 32'(lvl));
  endtask
  initial begin
    #100000;
    fails++;
    results();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(1);
    chk(32'({pd2, pd3, pu4, core_reset_n}), 32'he);
    chk(32'({p2i[3:2], p3i[4]}), 32'h1);
    cyc(1);
    hresetn <= 1'b1; ext3[4] <= 1'b0; ext2_en <= 8'hff; ext3_en <= 8'hff;
    cyc(4);
    chk(32'(core_reset_n), 32'h0);
    ext3[4] <= 1'b1;
    cyc(1);
    chk(32'(core_reset_n), 32'h0);
    wait_core(1'b1);
    chk(32'({pd2, pd3, pu4}), 32'h0);
    xfer(1'b0, `PPR_OFF_CFG_STAT, 32'h0);
    chk(rv, 32'h0);
    ext3[4] <= 1'b0;
    cyc(5);
    chk(32'(core_reset_n), 32'h1);
    ext3[4] <= 1'b1;
    xfer(1'b1, `PPR_OFF_CFG_STAT, 32'h1ff);
    xfer(1'b0, `PPR_OFF_CFG_STAT, 32'h0);
    chk(rv, 32'h0);
    xfer(1'b0, `PPR_OFF_INT_MASK, 32'h0);
    chk(rv, 32'h3);
    for (int p = 0; p < 2; p++) begin
      m = p ? 8'hfb : 8'hfd;
      xfer(1'b1, p ? `PPR_OFF_P3_MODE : `PPR_OFF_P2_MODE, 32'(m));
      xfer(1'b1, `PPR_OFF_INT_STAT, 32'h3);
      xfer(1'b1, p ? `PPR_OFF_P3_LATCH : `PPR_OFF_P2_LATCH, 32'(~m));
      cyc(2);
      xfer(1'b0, `PPR_OFF_INT_STAT, 32'h0);
      chk(rv, 32'(1 << p));
      chk(32'(irq), 32'h0);
      xfer(1'b1, `PPR_OFF_INT_MASK, 32'(~(1 << p) & 3));
      cyc(1);
      chk(32'(irq), 32'h1);
      xfer(1'b1, `PPR_OFF_INT_STAT, 32'(1 << p));
      cyc(1);
      chk(32'(irq), 32'h0);
      xfer(1'b1, `PPR_OFF_INT_MASK, 32'h3);
    end
    for (int n = 0; n < 16; n++) begin
      lf = lfsr(lf);
      m = lf[15:8] | (lf[0] ? 8'h10 : 8'h00);
      lat = lf[23:16];
      pins = lf[31:24] | (lf[0] ? 8'h10 : 8'h00);
      if (lf[0]) ext3 <= pins;
      else ext2 <= pins;
      xfer(1'b1, lf[0] ? `PPR_OFF_P3_MODE : `PPR_OFF_P2_MODE, 32'(m));
      xfer(1'b1, lf[0] ? `PPR_OFF_P3_LATCH : `PPR_OFF_P2_LATCH, 32'(lat));
      xfer(1'b1, `PPR_OFF_BIT_OP, {23'h0, lf[4], 4'h0, lf[0], lf[3:1]});
      ex = (lat & ~m) | (pins & m);
      ex[lf[3:1]] = lf[4];
      xfer(1'b0, lf[0] ? `PPR_OFF_P3_LATCH : `PPR_OFF_P2_LATCH, 32'h0);
      chk(rv, 32'(ex));
      chk(lf[0] ? {p3e, p3o} : {p2e, p2o}, {~m & (lf[0] ? 8'hef : 8'hff), ex});
    end
    xfer(1'b1, 32'h40, 32'hffffffff);
    xfer(1'b0, 32'h40, 32'h0);
    chk(rv, 32'h0);
    chk(32'(hresp), 32'h0);
    hsize <= 3'h0;
    xfer(1'b1, `PPR_OFF_INT_MASK, 32'h0);
    hsize <= 3'h2;
    xfer(1'b0, `PPR_OFF_INT_MASK, 32'h0);
    chk(rv, 32'h3);
    hresetn <= 1'b0; cfg_byte <= 8'h01;
    cyc(2);
    hresetn <= 1'b1;
    wait_core(1'b1);
    xfer(1'b0, `PPR_OFF_CFG_STAT, 32'h0);
    chk(rv, 32'h101);
    ext3[4] <= 1'b0;
    wait_core(1'b0);
    chk(32'({pd2, pd3, pu4}), 32'h7);
    ext3[4] <= 1'b1;
    wait_core(1'b1);
    results();
  end
endmodule // ppr_port_top_tb_top
